//--- shared/pmr_pkg.sv
package pmr_pkg;

    // Register port geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 24;

    // Register offsets
    localparam logic [ADDR_W-1:0] ADDR_CFG   = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_CAL   = 8'h01;
    localparam logic [ADDR_W-1:0] ADDR_SHUNT = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_BUS   = 8'h05;
    localparam logic [ADDR_W-1:0] ADDR_TEMP  = 8'h06;
    localparam logic [ADDR_W-1:0] ADDR_CUR   = 8'h07;
    localparam logic [ADDR_W-1:0] ADDR_PWR   = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_MAKER = 8'h3E;

    // Identity value; arbitrary neutral code
    localparam logic [15:0] MAKER_ID = 16'h4D50;

    // Field widths and positions
    localparam int CFG_W    = 8;
    localparam int CAL_W    = 15;
    localparam int RES_W    = 16;
    localparam int BUS_W    = 15;
    localparam int TEMP_W   = 12;
    localparam int TEMP_LSB = 4;
    localparam int PWR_W    = 24;
    localparam int ACC_W    = 27;
    localparam int CNT_W    = 11;
    localparam int SHF_W    = 4;
    localparam int TMR_W    = 32;

    // Scaling of the derived results
    localparam int CUR_SHIFT = 11;
    localparam int PWR_SHIFT = 6;

    // Clock rate; one microsecond is CLK_MHZ cycles
    localparam int CLK_MHZ = 250;

    typedef enum logic [1:0] {CH_SHUNT, CH_BUS, CH_TEMP} pmr_chan_e;

    typedef struct packed {
        pmr_chan_e         chan;
        logic [RES_W-1:0]  data;
    } pmr_sample_s;

    // Config register layout, bit 0 upward: run, range, conv time, averaging
    typedef struct packed {
        logic [2:0] avg_code;
        logic [2:0] conv_code;
        logic       shunt_range_select;
        logic       run;
    } pmr_cfg_s;

    localparam pmr_cfg_s CFG_RESET = 8'h00;

    // Conversion time in microseconds per code
    function automatic int unsigned conv_us(input logic [2:0] code);
        case (code)
            3'h0:    conv_us = 50;
            3'h1:    conv_us = 84;
            3'h2:    conv_us = 150;
            3'h3:    conv_us = 280;
            3'h4:    conv_us = 540;
            3'h5:    conv_us = 1052;
            3'h6:    conv_us = 2074;
            default: conv_us = 4120;
        endcase
    endfunction

    // Averaging count as a power of two: 1,4,16,64,128,256,512,1024
    function automatic logic [SHF_W-1:0] avg_shift(input logic [2:0] code);
        case (code)
            3'h0:    avg_shift = 4'h0;
            3'h1:    avg_shift = 4'h2;
            3'h2:    avg_shift = 4'h4;
            3'h3:    avg_shift = 4'h6;
            3'h4:    avg_shift = 4'h7;
            3'h5:    avg_shift = 4'h8;
            3'h6:    avg_shift = 4'h9;
            default: avg_shift = 4'hA;
        endcase
    endfunction

endpackage

//--- logic/pmr_avg.sv
`timescale 1ns/100ps
module pmr_avg
    import pmr_pkg::*;
(
    input  wire logic                    clk_sys_i,
    input  wire logic                    arst_n_i,
    input  wire logic                    clr_i,
    input  wire logic [SHF_W-1:0]        shift_i,
    input  wire logic                    smp_valid_i,
    input  wire logic signed [RES_W-1:0] smp_i,
    output logic                         avg_valid_o,
    output logic signed [RES_W-1:0]      avg_o
);

    logic signed [ACC_W-1:0] acc_r, acc_nxt, acc_sum;
    logic [CNT_W-1:0]        cnt_r, cnt_nxt;
    logic                    vld_nxt;
    logic signed [RES_W-1:0] avg_nxt;

    // Sum samples; a power-of-two count lets an arithmetic shift divide
    always_comb
    begin
        acc_sum = acc_r + ACC_W'(smp_i);
        acc_nxt = acc_r;
        cnt_nxt = cnt_r;
        vld_nxt = 1'b0;
        avg_nxt = avg_o;
        if (clr_i)
        begin
            acc_nxt = '0;
            cnt_nxt = '0;
        end
        else if (smp_valid_i)
        begin
            if ((cnt_r + CNT_W'(1)) == (CNT_W'(1) << shift_i))
            begin
                avg_nxt = RES_W'(acc_sum >>> shift_i);
                vld_nxt = 1'b1;
                acc_nxt = '0;
                cnt_nxt = '0;
            end
            else
            begin
                acc_nxt = acc_sum;
                cnt_nxt = cnt_r + CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            acc_r       <= '0;
            cnt_r       <= '0;
            avg_valid_o <= 1'b0;
            avg_o       <= '0;
        end
        else
        begin
            acc_r       <= acc_nxt;
            cnt_r       <= cnt_nxt;
            avg_valid_o <= vld_nxt;
            avg_o       <= avg_nxt;
        end
    end

endmodule

//--- logic/pmr_core.sv
`timescale 1ns/100ps
// Functional notes
// - Read-only fixed maker identity, writes ignored
// - Range bit: clear 5 uV, set 1.25 uV
// - Shunt result is 16-bit signed
// - Bus result non-negative, 3.125 mV steps
// - Temperature 12-bit signed, 125 mdegC steps
// - Current recomputed after each shunt result
// - Zero calibration forces zero current
// - Power is 24-bit, 0.2 current step
// - Selectable conversion time, 50 us to 4120 us, and averaging, 1 to 1024 samples
module pmr_core
    import pmr_pkg::*;
#(
    parameter int unsigned US_CYCLES = CLK_MHZ
)
(
    input  wire logic              clk_sys_i,
    input  wire logic              arst_n_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wr_data_i,
    input  wire logic              wr_en_i,
    input  wire logic              rd_en_i,
    output logic [DATA_W-1:0]      rd_data_o,
    input  wire logic              adc_valid_i,
    input  wire pmr_sample_s       adc_smp_i,
    output logic                   conv_start_o,
    output pmr_chan_e              conv_chan_o,
    output logic                   adc_range_o
);

    typedef enum logic [1:0] {ST_IDLE, ST_START, ST_CONV} pmr_state_e;

    // Saturate a signed value to the 16-bit current range
    function automatic logic signed [RES_W-1:0] sat_res(input logic signed [31:0] v);
        if (v > 32'sd32767)
            sat_res = 16'h7FFF;
        else if (v < -32'sd32768)
            sat_res = 16'h8000;
        else
            sat_res = RES_W'(v);
    endfunction

    pmr_cfg_s                cfg_r, cfg_nxt;
    logic [CAL_W-1:0]        cal_r, cal_nxt;
    logic signed [RES_W-1:0] shunt_r, shunt_nxt;
    logic [BUS_W-1:0]        bus_r, bus_nxt;
    logic signed [TEMP_W-1:0] temp_r, temp_nxt;
    logic signed [RES_W-1:0] cur_r, cur_nxt;
    logic [PWR_W-1:0]        pwr_r, pwr_nxt;
    logic                    cur_pend_r, cur_pend_nxt;
    logic                    pwr_pend_r, pwr_pend_nxt;
    logic [DATA_W-1:0]       rd_data_nxt;
    pmr_state_e              state_r, state_nxt;
    logic [TMR_W-1:0]        tmr_r, tmr_nxt;
    pmr_chan_e               chan_nxt;
    logic                    start_nxt;
    logic                    avg_clr;
    logic                    avg_v [3];
    logic signed [RES_W-1:0] avg_d [3];
    logic signed [31:0]      cur_prod;
    logic [RES_W:0]          cur_mag;
    logic [31:0]             pwr_prod;
    logic [31:0]             pwr_scaled;

    // A config write restarts averaging so no mean mixes two settings
    assign avg_clr = wr_en_i && (addr_i == ADDR_CFG);

    // One averager per measured channel
    for (genvar ch = 0; ch < 3; ch++)
    begin : g_avg
        pmr_avg u_avg (
            .clk_sys_i   (clk_sys_i),
            .arst_n_i    (arst_n_i),
            .clr_i       (avg_clr),
            .shift_i     (avg_shift(cfg_r.avg_code)),
            .smp_valid_i (adc_valid_i && (adc_smp_i.chan == pmr_chan_e'(ch))),
            .smp_i       (adc_smp_i.data),
            .avg_valid_o (avg_v[ch]),
            .avg_o       (avg_d[ch])
        );
    end

    // Conversion sequencer: start, wait the selected time, next channel
    always_comb
    begin
        state_nxt = state_r;
        tmr_nxt   = tmr_r;
        chan_nxt  = conv_chan_o;
        unique case (state_r)
            ST_IDLE:
            begin
                if (cfg_r.run)
                    state_nxt = ST_START;
            end
            ST_START:
            begin
                tmr_nxt   = TMR_W'(conv_us(cfg_r.conv_code) * US_CYCLES);
                state_nxt = ST_CONV;
            end
            ST_CONV:
            begin
                tmr_nxt = tmr_r - TMR_W'(1);
                if (tmr_r <= TMR_W'(1))
                begin
                    chan_nxt  = (conv_chan_o == CH_TEMP) ? CH_SHUNT
                                : pmr_chan_e'(conv_chan_o + 2'h1);
                    state_nxt = cfg_r.run ? ST_START : ST_IDLE;
                end
            end
            // Two-bit state has one unused code; fall back to idle
            default: state_nxt = ST_IDLE;
        endcase
        start_nxt = (state_nxt == ST_START);
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            state_r      <= ST_IDLE;
            tmr_r        <= '0;
            conv_chan_o  <= CH_SHUNT;
            conv_start_o <= 1'b0;
        end
        else
        begin
            state_r      <= state_nxt;
            tmr_r        <= tmr_nxt;
            conv_chan_o  <= chan_nxt;
            conv_start_o <= start_nxt;
        end
    end

    // Current and power arithmetic; the power uses the last bus result
    always_comb
    begin
        cur_prod   = 32'(shunt_r) * $signed({1'b0, cal_r});
        cur_mag    = cur_r[RES_W-1] ? (RES_W+1)'(-(RES_W+1)'(cur_r)) : (RES_W+1)'(cur_r);
        pwr_prod   = 32'(cur_mag) * 32'(bus_r);
        pwr_scaled = pwr_prod >> PWR_SHIFT;
    end

    // Register writes and result updates
    always_comb
    begin
        cfg_nxt      = cfg_r;
        cal_nxt      = cal_r;
        shunt_nxt    = shunt_r;
        bus_nxt      = bus_r;
        temp_nxt     = temp_r;
        cur_nxt      = cur_r;
        pwr_nxt      = pwr_r;
        cur_pend_nxt = 1'b0;
        pwr_pend_nxt = 1'b0;
        if (wr_en_i)
        begin
            // Identity and results ignore writes
            if (addr_i == ADDR_CFG)
                cfg_nxt = pmr_cfg_s'(wr_data_i[CFG_W-1:0]);
            else if (addr_i == ADDR_CAL)
                cal_nxt = wr_data_i[CAL_W-1:0];
        end
        if (avg_v[CH_SHUNT])
        begin
            shunt_nxt    = avg_d[CH_SHUNT];
            cur_pend_nxt = 1'b1;
        end
        if (avg_v[CH_BUS])
            bus_nxt = avg_d[CH_BUS][RES_W-1] ? '0 : avg_d[CH_BUS][BUS_W-1:0];
        if (avg_v[CH_TEMP])
            temp_nxt = avg_d[CH_TEMP][RES_W-1:TEMP_LSB];
        if (cur_pend_r)
        begin
            // Zero calibration must give zero even if the product were odd
            cur_nxt      = (cal_r == '0) ? '0
                           : sat_res(cur_prod >>> CUR_SHIFT);
            pwr_pend_nxt = 1'b1;
        end
        if (pwr_pend_r)
            pwr_nxt = (pwr_scaled > 32'(24'hFFFFFF)) ? 24'hFFFFFF
                      : pwr_scaled[PWR_W-1:0];
    end

    // Read mux; data stand only in the cycle after the strobe
    always_comb
    begin
        rd_data_nxt = '0;
        if (rd_en_i)
        begin
            case (addr_i)
                ADDR_CFG:   rd_data_nxt = DATA_W'(cfg_r);
                ADDR_CAL:   rd_data_nxt = DATA_W'(cal_r);
                ADDR_SHUNT: rd_data_nxt = DATA_W'($unsigned(shunt_r));
                ADDR_BUS:   rd_data_nxt = DATA_W'(bus_r);
                ADDR_TEMP:  rd_data_nxt = DATA_W'({temp_r, 4'h0});
                ADDR_CUR:   rd_data_nxt = DATA_W'($unsigned(cur_r));
                ADDR_PWR:   rd_data_nxt = pwr_r;
                ADDR_MAKER: rd_data_nxt = DATA_W'(MAKER_ID);
                default:    rd_data_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cfg_r       <= CFG_RESET;
            cal_r       <= '0;
            shunt_r     <= '0;
            bus_r       <= '0;
            temp_r      <= '0;
            cur_r       <= '0;
            pwr_r       <= '0;
            cur_pend_r  <= 1'b0;
            pwr_pend_r  <= 1'b0;
            rd_data_o   <= '0;
            adc_range_o <= 1'b0;
        end
        else
        begin
            cfg_r       <= cfg_nxt;
            cal_r       <= cal_nxt;
            shunt_r     <= shunt_nxt;
            bus_r       <= bus_nxt;
            temp_r      <= temp_nxt;
            cur_r       <= cur_nxt;
            pwr_r       <= pwr_nxt;
            cur_pend_r  <= cur_pend_nxt;
            pwr_pend_r  <= pwr_pend_nxt;
            rd_data_o   <= rd_data_nxt;
            adc_range_o <= cfg_nxt.shunt_range_select;
        end
    end

    // Checks on the documented behaviour
    AST_MAKER_ID: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        rd_en_i && (addr_i == ADDR_MAKER) |=> rd_data_o == DATA_W'(MAKER_ID))
        else $error("identity read wrong");

    AST_RANGE_OUT: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        wr_en_i && (addr_i == ADDR_CFG) |=> adc_range_o == $past(wr_data_i[1]))
        else $error("range select not applied");

    AST_SHUNT_LOAD: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        avg_v[CH_SHUNT] |=> shunt_r == $past(avg_d[CH_SHUNT]))
        else $error("shunt result not loaded");

    AST_BUS_NONNEG: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        avg_v[CH_BUS] && avg_d[CH_BUS][RES_W-1] |=> bus_r == '0)
        else $error("bus result negative");

    AST_TEMP_FMT: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        rd_en_i && (addr_i == ADDR_TEMP) |=> rd_data_o == DATA_W'({$past(temp_r), 4'h0}))
        else $error("temperature low bits set");

    AST_CUR_AFTER: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        avg_v[CH_SHUNT] |=> ##1
        cur_r == (($past(cal_r) == '0) ? '0
                  : sat_res((32'($past(shunt_r)) * $signed({1'b0, $past(cal_r)})) >>> CUR_SHIFT)))
        else $error("current not updated after shunt");

    AST_CUR_ZERO: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        cur_pend_r && (cal_r == '0) |=> cur_r == '0)
        else $error("current nonzero with zero calibration");

    AST_PWR_FOLLOW: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        avg_v[CH_SHUNT] |=> cur_pend_r ##1 pwr_pend_r)
        else $error("power not computed after current");

    AST_CONV_GAP: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        conv_start_o |=> !conv_start_o [*2])
        else $error("conversions too close");

    AST_PWR_SAT: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
        pwr_pend_r |=> 32'(pwr_r) == (($past(pwr_scaled) > 32'h00FFFFFF) ? 32'h00FFFFFF
                                      : $past(pwr_scaled)))
        else $error("power wrapped");

endmodule

//--- testbench/pmr_adc_model.sv
`timescale 1ns/100ps
module pmr_adc_model
    import pmr_pkg::*;
#(
    parameter int LAT = 5
)
(
    input  wire logic             clk_sys_i,
    input  wire logic             arst_n_i,
    input  wire logic             conv_start_i,
    input  wire pmr_chan_e        conv_chan_i,
    input  wire logic [RES_W-1:0] shunt_i,
    input  wire logic [RES_W-1:0] bus_i,
    input  wire logic [RES_W-1:0] temp_i,
    output logic                  adc_valid_o,
    output pmr_sample_s           adc_smp_o
);
    logic [7:0]       cnt_r;
    pmr_chan_e        chan_r;
    logic [RES_W-1:0] last_r;
    logic [RES_W-1:0] sel;

    // Analog value of the channel under conversion
    always_comb
    begin
        case (chan_r)
            CH_SHUNT: sel = shunt_i;
            CH_BUS:   sel = bus_i;
            default:  sel = temp_i;
        endcase
    end

    // Fixed latency from start to one-cycle result pulse
    always_ff @(posedge clk_sys_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            cnt_r       <= 8'h00;
            chan_r      <= CH_SHUNT;
            adc_valid_o <= 1'b0;
            last_r      <= 16'h0000;
        end
        else
        begin
            adc_valid_o <= 1'b0;
            if (conv_start_i)
            begin
                cnt_r  <= 8'(LAT);
                chan_r <= conv_chan_i;
            end
            else if (cnt_r != 8'h00)
            begin
                cnt_r <= cnt_r - 8'h01;
                if (cnt_r == 8'h01)
                begin
                    adc_valid_o <= 1'b1;
                    last_r      <= sel;
                end
            end
        end
    end

    // Outside the pulse the data bus shows the inverse, so stale values never match
    assign adc_smp_o.chan = chan_r;
    assign adc_smp_o.data = adc_valid_o ? last_r : ~last_r;
endmodule

//--- testbench/power_monitor_result_scaling_test.sv
`timescale 1ns/100ps
module power_monitor_result_scaling_test;
    import pmr_pkg::*;

    logic              clk_sys_i = 1'b0;
    logic              arst_n_i  = 1'b0;
    logic [ADDR_W-1:0] addr_i    = 8'h00;
    logic [DATA_W-1:0] wr_data_i = 24'h000000;
    logic              wr_en_i   = 1'b0;
    logic              rd_en_i   = 1'b0;
    logic [DATA_W-1:0] rd_data_o;
    logic              adc_valid_i;
    pmr_sample_s       adc_smp_i;
    logic              conv_start_o;
    pmr_chan_e         conv_chan_o;
    logic              adc_range_o;
    logic [RES_W-1:0]  sh_v = 16'h0000;
    logic [RES_W-1:0]  bs_v = 16'h0000;
    logic [RES_W-1:0]  tp_v = 16'h0000;
    int                err_count = 0;
    int                tests_run = 0;
    int                cyc = 0;
    int                n1;
    int                n2;
    // shunt, bus, temp, cal, cfg, then shunt, bus, temp, current, power readings
    logic [23:0]       tbl [4][10] = '{
        '{24'hF000, 24'h1000, 24'hFF80, 24'h0800, 24'h01,
          24'hF000, 24'h1000, 24'hFF80, 24'hF000, 24'h040000},
        '{24'h8000, 24'h7FFF, 24'h7FFF, 24'h7FFF, 24'h01,
          24'h8000, 24'h7FFF, 24'h7FF0, 24'h8000, 24'hFFFE00},
        '{24'h1234, 24'h8000, 24'h0010, 24'h0000, 24'h01,
          24'h1234, 24'h0000, 24'h0010, 24'h0000, 24'h000000},
        '{24'h0400, 24'h0040, 24'h0000, 24'h1000, 24'h03,
          24'h0400, 24'h0040, 24'h0000, 24'h0800, 24'h000800}};
    int                conv_tbl [3] = '{50, 84, 150};
    // Channel that follows each channel in the rotation
    pmr_chan_e         nxt_ch [3] = '{CH_BUS, CH_TEMP, CH_SHUNT};
    pmr_chan_e         ch_a;

    always #2 clk_sys_i = ~clk_sys_i;

    pmr_core #(.US_CYCLES(1)) DUT (
        .clk_sys_i    (clk_sys_i),
        .arst_n_i     (arst_n_i),
        .addr_i       (addr_i),
        .wr_data_i    (wr_data_i),
        .wr_en_i      (wr_en_i),
        .rd_en_i      (rd_en_i),
        .rd_data_o    (rd_data_o),
        .adc_valid_i  (adc_valid_i),
        .adc_smp_i    (adc_smp_i),
        .conv_start_o (conv_start_o),
        .conv_chan_o  (conv_chan_o),
        .adc_range_o  (adc_range_o)
    );

    pmr_adc_model #(.LAT(5)) adc (
        .clk_sys_i    (clk_sys_i),
        .arst_n_i     (arst_n_i),
        .conv_start_i (conv_start_o),
        .conv_chan_i  (conv_chan_o),
        .shunt_i      (sh_v),
        .bus_i        (bs_v),
        .temp_i       (tp_v),
        .adc_valid_o  (adc_valid_i),
        .adc_smp_o    (adc_smp_i)
    );

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        @(posedge clk_sys_i);
        addr_i    <= a;
        wr_data_i <= d;
        wr_en_i   <= 1'b1;
        @(posedge clk_sys_i);
        wr_en_i   <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [23:0] exp);
        @(posedge clk_sys_i);
        addr_i  <= a;
        rd_en_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_en_i <= 1'b0;
        #1;
        check(rd_data_o, exp);
    endtask

    // Edges until the next start pulse, bounded
    task automatic next_start(output int n);
        n = 0;
        do
        begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end
        while (conv_start_o !== 1'b1 && n < 5000);
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Hang guard; the full sequence needs about 3000 cycles
    always @(posedge clk_sys_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            summarize();
        end
    end

    initial
    begin
        repeat (16) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        // Identity is fixed, ignores writes; unmapped space reads zero
        rd(ADDR_MAKER, {8'h00, MAKER_ID});
        wr(ADDR_MAKER, 24'hFFFFFF);
        rd(ADDR_MAKER, {8'h00, MAKER_ID});
        rd(8'h02, 24'h000000);
        rd(ADDR_CFG, 24'h000000);
        rd(ADDR_CAL, 24'h000000);
        wr(ADDR_CAL, 24'hFFFFFF);
        rd(ADDR_CAL, 24'h007FFF);
        // Range bit reaches the front end at once
        wr(ADDR_CFG, 24'h000002);
        #1;
        check(adc_range_o, 1'b1);
        rd(ADDR_CFG, 24'h000002);
        wr(ADDR_CFG, 24'h000000);
        #1;
        check(adc_range_o, 1'b0);
        // Result coding, current and power from live calibration
        for (int i = 0; i < 4; i++)
        begin
            sh_v = tbl[i][0][15:0];
            bs_v = tbl[i][1][15:0];
            tp_v = tbl[i][2][15:0];
            wr(ADDR_CAL, tbl[i][3]);
            wr(ADDR_CFG, tbl[i][4]);
            // Two full rotations so power sees the new bus value too
            repeat (400) @(posedge clk_sys_i);
            check(adc_range_o, tbl[i][4][1]);
            rd(ADDR_SHUNT, tbl[i][5]);
            rd(ADDR_BUS, tbl[i][6]);
            rd(ADDR_TEMP, tbl[i][7]);
            rd(ADDR_CUR, tbl[i][8]);
            rd(ADDR_PWR, tbl[i][9]);
        end
        // Start spacing follows the conversion time code
        for (int c = 0; c < 3; c++)
        begin
            wr(ADDR_CFG, 24'(c * 4 + 1));
            next_start(n1);
            ch_a = conv_chan_o;
            next_start(n2);
            check(24'(n2), 24'(conv_tbl[c] + 1));
            check(24'(conv_chan_o), 24'(nxt_ch[ch_a]));
        end
        // Four-sample averaging holds the old result until four samples land
        sh_v = 16'h0100;
        wr(ADDR_CFG, 24'h000021);
        repeat (300) @(posedge clk_sys_i);
        rd(ADDR_SHUNT, 24'h000400);
        repeat (500) @(posedge clk_sys_i);
        rd(ADDR_SHUNT, 24'h000100);
        summarize();
    end
endmodule
